// ---- core/ppm_pkg.sv ----
// Shared constants, types and decode for the port pin override mux
package ppm_pkg;
	// ------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------
	localparam int PORT_W = 8;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] FLAG_RST = 8'h00;
	localparam logic [7:0] PREV_RST = 8'h00;
	localparam logic SYNC_RST = 1'h0;
	// Direction, latch, pull-up disable pattern that turns the pull-up on
	localparam logic [2:0] PULLUP_CODE = 3'h2;

	// ------------------------------------------------------------
	// Port A alternate function pin positions
	// ------------------------------------------------------------
	localparam int PIN_T0_SRC = 3;
	localparam int PIN_USI_CLK = 4;
	localparam int PIN_T1_SRC = 4;
	localparam int PIN_T1_CMPB = 5;
	localparam int PIN_USI_DO = 5;
	localparam int PIN_T1_CMPA = 6;
	localparam int PIN_USI_DI = 6;
	localparam int PIN_T0_CMPB = 7;
	localparam int PIN_T1_CAP = 7;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SLP_ACTIVE,
		SLP_IDLE,
		SLP_POWER_DOWN,
		SLP_POWER_SAVE,
		SLP_STANDBY
	} ppm_sleep_e;

	typedef enum logic [1:0] {
		SENSE_LOW,
		SENSE_ANY,
		SENSE_FALL,
		SENSE_RISE
	} ppm_sense_e;

	typedef struct packed {
		logic pullup_override_enable;
		logic pullup_override_value;
		logic direction_override_enable;
		logic direction_override_value;
		logic value_override_enable;
		logic value_override_value;
		logic toggle_override_enable;
		logic input_enable_override_enable;
		logic input_enable_override_value;
	} ppm_ovr_s;

	// Deep sleep states clamp the digital inputs
	function automatic logic ppm_is_deep(input ppm_sleep_e mode);
		return (mode == SLP_POWER_DOWN) || (mode == SLP_POWER_SAVE) ||
			(mode == SLP_STANDBY);
	endfunction
endpackage

// ---- core/ppm_pin_cell.sv ----
// One port pin: override selection, input clamp and pin synchroniser
`timescale 1ns/100ps
`default_nettype none
module ppm_pin_cell (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Register bits and shared controls
	input wire logic i_direction_bit,
	input wire logic i_output_latch_bit,
	input wire logic i_global_pullup_disable,
	input wire logic i_sleep_clamp,
	input wire logic i_ext_int_en,
	// Overrides from the peripheral owning the pin
	input wire ppm_pkg::ppm_ovr_s i_ovr,
	// Pad
	input wire logic i_pad_in,
	output logic o_pad_out,
	output logic o_pad_oe,
	output logic o_pullup,
	// Toward the core
	output logic o_input_en,
	output logic o_alternate_digital_input,
	output logic o_pin_input_bit
);
	logic sync_lo_r;
	logic pin_input_r;
	logic gated_in;

	// ------------------------------------------------------------
	// Override multiplexers
	// ------------------------------------------------------------
	always_comb begin
		if (i_ovr.pullup_override_enable) begin
			o_pullup = i_ovr.pullup_override_value;
		end else begin
			o_pullup = ({i_direction_bit, i_output_latch_bit, i_global_pullup_disable}
				== ppm_pkg::PULLUP_CODE);
		end
		if (i_sys_rst) begin
			o_pullup = 1'b0;
		end
		o_pad_oe = i_ovr.direction_override_enable ?
			i_ovr.direction_override_value : i_direction_bit;
		if (!o_pad_oe) begin
			o_pad_out = 1'b0;
		end else if (i_ovr.value_override_enable) begin
			o_pad_out = i_ovr.value_override_value;
		end else begin
			o_pad_out = i_output_latch_bit;
		end
		if (i_ovr.input_enable_override_enable) begin
			o_input_en = i_ovr.input_enable_override_value;
		end else begin
			o_input_en = ~i_sleep_clamp | i_ext_int_en;
		end
	end

	// Clamp to ground ahead of the input buffer; peripherals see it unsynchronised
	assign gated_in = i_pad_in & o_input_en;
	assign o_alternate_digital_input = gated_in;

	// ------------------------------------------------------------
	// Synchroniser: low phase stage then rising edge stage
	// ------------------------------------------------------------
	always_ff @(negedge i_core_clk) begin
		if (i_sys_rst) begin
			sync_lo_r <= ppm_pkg::SYNC_RST;
		end else begin
			sync_lo_r <= gated_in;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			pin_input_r <= ppm_pkg::SYNC_RST;
		end else begin
			pin_input_r <= sync_lo_r;
		end
	end

	assign o_pin_input_bit = pin_input_r;
endmodule
`default_nettype wire

// ---- core/ppm_port.sv ----
// Port A pin override mux top: registers, sleep clamp, alternate routing
// Notes on behaviour
// - Deep sleep states clamp digital inputs to ground, except pins with an enabled interrupt or an input enable override.
// - An enabled external interrupt keeps its pin input live in sleep.
// - Clamp release on a high rise- or any-edge-sensed pin sets its interrupt flag.
// - Reset, active and idle leave inputs enabled and unclamped.
// - Pull-up is off while reset is held.
// - Pull-up follows its override, else on for code 010.
// - Driver enable follows direction override, else direction bit.
// - Driven value follows value override, else output latch bit.
// - Toggle override inverts the output latch bit.
// - Input enable follows its override, else the sleep state.
// - Alternate digital input is taken before the synchroniser.
// - Overrides per pin; strobes per port; clamp and disable shared.
// - Pins 0 to 7 feed pin change sources 0 to 7.
// - Serial clock on pin 4, data out pin 5, data in pin 6.
// - Timer 1 compare B drives pin 5, compare A pin 6.
// - Pin 7: timer 0 compare B out and timer 1 capture in.
// - Pin 3 is the timer 0 external count source.
// - Pin 4 is also the timer 1 external count source.
// - Direction one makes an output; latch one on input pulls up.
// - Writing one to the input register toggles the latch bit.
// - Pin input passes a half-cycle stage and a flip-flop.
`timescale 1ns/100ps
`default_nettype none
module ppm_port (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Port strobes and data, shared by all pins
	input wire logic i_direction_wr,
	input wire logic [7:0] i_direction_wdata,
	input wire logic i_latch_wr,
	input wire logic [7:0] i_latch_wdata,
	input wire logic i_pin_wr,
	input wire logic [7:0] i_pin_wdata,
	output logic [7:0] o_direction,
	output logic [7:0] o_output_latch,
	output logic [7:0] o_pin_input,
	// Shared controls
	input wire logic i_global_pullup_disable,
	input wire ppm_pkg::ppm_sleep_e i_sleep_mode,
	output logic o_sleep_clamp,
	// External interrupt sense and flags
	input wire logic [7:0] i_ext_int_en,
	input wire ppm_pkg::ppm_sense_e [7:0] i_ext_int_sense,
	input wire logic [7:0] i_ext_int_flag_clr,
	output logic [7:0] o_ext_int_flag,
	// Generic per-pin overrides
	input wire ppm_pkg::ppm_ovr_s [7:0] i_ovr,
	// Peripheral outputs toward pins
	input wire logic i_usi_data_out,
	input wire logic i_usi_data_out_en,
	input wire logic i_timer1_compare_a_out,
	input wire logic i_timer1_compare_a_en,
	input wire logic i_timer1_compare_b_out,
	input wire logic i_timer1_compare_b_en,
	input wire logic i_timer0_compare_b_out,
	input wire logic i_timer0_compare_b_en,
	// Pin inputs toward peripherals
	output logic [7:0] o_pin_change_source,
	output logic o_serial_iface_clock_pin,
	output logic o_usi_data_in,
	output logic o_timer0_count_source,
	output logic o_timer1_count_source,
	output logic o_timer1_capture_in,
	// Pads
	input wire logic [7:0] i_pad_in,
	output logic [7:0] o_pad_out,
	output logic [7:0] o_pad_oe,
	output logic [7:0] o_pullup,
	output logic [7:0] o_input_en
);
	logic [7:0] direction_r;
	logic [7:0] latch_r;
	logic [7:0] latch_nxt;
	logic [7:0] flag_r;
	logic [7:0] flag_set;
	logic [7:0] prev_r;
	logic [7:0] alt_di;
	logic [7:0] toggle_ovr;
	logic [7:0] ie_ovr_en;
	logic sleep_clamp;
	ppm_pkg::ppm_ovr_s [7:0] ovr_eff;

	// ------------------------------------------------------------
	// Shared sleep clamp
	// ------------------------------------------------------------
	// Never clamped while reset is held
	assign sleep_clamp = ppm_pkg::ppm_is_deep(i_sleep_mode) & ~i_sys_rst;
	assign o_sleep_clamp = sleep_clamp;

	// ------------------------------------------------------------
	// Alternate function overrides on pins 5 to 7
	// ------------------------------------------------------------
	always_comb begin
		ovr_eff = i_ovr;
		if (i_usi_data_out_en) begin
			ovr_eff[ppm_pkg::PIN_USI_DO].value_override_enable = 1'b1;
			ovr_eff[ppm_pkg::PIN_USI_DO].value_override_value = i_usi_data_out;
		end else if (i_timer1_compare_b_en) begin
			ovr_eff[ppm_pkg::PIN_T1_CMPB].value_override_enable = 1'b1;
			ovr_eff[ppm_pkg::PIN_T1_CMPB].value_override_value =
				i_timer1_compare_b_out;
		end
		if (i_timer1_compare_a_en) begin
			ovr_eff[ppm_pkg::PIN_T1_CMPA].value_override_enable = 1'b1;
			ovr_eff[ppm_pkg::PIN_T1_CMPA].value_override_value =
				i_timer1_compare_a_out;
		end
		if (i_timer0_compare_b_en) begin
			ovr_eff[ppm_pkg::PIN_T0_CMPB].value_override_enable = 1'b1;
			ovr_eff[ppm_pkg::PIN_T0_CMPB].value_override_value =
				i_timer0_compare_b_out;
		end
	end

	// ------------------------------------------------------------
	// Per-pin cells
	// ------------------------------------------------------------
	for (genvar n = 0; n < ppm_pkg::PORT_W; n++) begin : g_pin
		assign toggle_ovr[n] = ovr_eff[n].toggle_override_enable;
		assign ie_ovr_en[n] = ovr_eff[n].input_enable_override_enable;
		// Own overrides per pin, shared clamp and pull-up disable
		ppm_pin_cell u_cell (
			.i_core_clk(i_core_clk),
			.i_sys_rst(i_sys_rst),
			.i_direction_bit(direction_r[n]),
			.i_output_latch_bit(latch_r[n]),
			.i_global_pullup_disable(i_global_pullup_disable),
			.i_sleep_clamp(sleep_clamp),
			.i_ext_int_en(i_ext_int_en[n]),
			.i_ovr(ovr_eff[n]),
			.i_pad_in(i_pad_in[n]),
			.o_pad_out(o_pad_out[n]),
			.o_pad_oe(o_pad_oe[n]),
			.o_pullup(o_pullup[n]),
			.o_input_en(o_input_en[n]),
			.o_alternate_digital_input(alt_di[n]),
			.o_pin_input_bit(o_pin_input[n])
		);
	end

	// ------------------------------------------------------------
	// Alternate inputs toward peripherals, unsynchronised
	// ------------------------------------------------------------
	assign o_pin_change_source = alt_di;
	assign o_serial_iface_clock_pin = alt_di[ppm_pkg::PIN_USI_CLK];
	assign o_usi_data_in = alt_di[ppm_pkg::PIN_USI_DI];
	assign o_timer0_count_source = alt_di[ppm_pkg::PIN_T0_SRC];
	assign o_timer1_count_source = alt_di[ppm_pkg::PIN_T1_SRC];
	assign o_timer1_capture_in = alt_di[ppm_pkg::PIN_T1_CAP];

	// ------------------------------------------------------------
	// Direction and output latch registers
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			direction_r <= ppm_pkg::DIR_RST;
		end else if (i_direction_wr) begin
			direction_r <= i_direction_wdata;
		end
	end

	always_comb begin
		latch_nxt = i_latch_wr ? i_latch_wdata : latch_r;
		if (i_pin_wr) begin
			latch_nxt = latch_nxt ^ i_pin_wdata;
		end
		latch_nxt = latch_nxt ^ toggle_ovr;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			latch_r <= ppm_pkg::LATCH_RST;
		end else begin
			latch_r <= latch_nxt;
		end
	end

	assign o_direction = direction_r;
	assign o_output_latch = latch_r;

	// ------------------------------------------------------------
	// External interrupt edge flags
	// ------------------------------------------------------------
	// Flags ignore the enable, so the clamp release edge is caught
	always_comb begin
		for (int k = 0; k < ppm_pkg::PORT_W; k++) begin
			case (i_ext_int_sense[k])
				ppm_pkg::SENSE_ANY: flag_set[k] = o_pin_input[k] ^ prev_r[k];
				ppm_pkg::SENSE_FALL: flag_set[k] = ~o_pin_input[k] & prev_r[k];
				ppm_pkg::SENSE_RISE: flag_set[k] = o_pin_input[k] & ~prev_r[k];
				default: flag_set[k] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			prev_r <= ppm_pkg::PREV_RST;
		end else begin
			prev_r <= o_pin_input;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			flag_r <= ppm_pkg::FLAG_RST;
		end else begin
			// Set wins over a clear in the same cycle
			flag_r <= (flag_r & ~i_ext_int_flag_clr) | flag_set;
		end
	end

	assign o_ext_int_flag = flag_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_CLAMP: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		ppm_pkg::ppm_is_deep(i_sleep_mode) |->
		((o_input_en & ~ie_ovr_en & ~i_ext_int_en) == 8'h00))
		else $error("input live in deep sleep without override");

	AST_EXT_LIVE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		((o_input_en | ie_ovr_en) & i_ext_int_en) == i_ext_int_en)
		else $error("enabled interrupt pin lost its input");

	AST_AWAKE: assert property (@(posedge i_core_clk)
		(i_sys_rst || i_sleep_mode == ppm_pkg::SLP_ACTIVE ||
		i_sleep_mode == ppm_pkg::SLP_IDLE) |-> !o_sleep_clamp)
		else $error("clamp active outside deep sleep");

	AST_PU_RST: assert property (@(posedge i_core_clk)
		i_sys_rst |-> (o_pullup == 8'h00))
		else $error("pull-up on during reset");

	AST_PU_CODE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(!ovr_eff[0].pullup_override_enable && !i_global_pullup_disable &&
		!o_direction[0] && o_output_latch[0]) |-> o_pullup[0])
		else $error("pin 0 pull-up missing for code 010");

	AST_DIR_OVR: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_direction_wr |=> (o_pad_oe[1] ==
		(ovr_eff[1].direction_override_enable ?
		ovr_eff[1].direction_override_value : $past(i_direction_wdata[1]))))
		else $error("pin 1 driver enable wrong after write");

	AST_VAL_T0: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(o_pad_oe[7] && i_timer0_compare_b_en) |->
		(o_pad_out[7] == i_timer0_compare_b_out))
		else $error("pin 7 not driven by timer 0 compare B");

	AST_TOGGLE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(toggle_ovr[4] && !i_latch_wr && !i_pin_wr) |=>
		(o_output_latch[4] != $past(o_output_latch[4])))
		else $error("pin 4 latch did not invert");

	AST_PIN_TGL: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_pin_wr && !i_latch_wr && toggle_ovr == 8'h00) |=>
		(o_output_latch == ($past(o_output_latch) ^ $past(i_pin_wdata))))
		else $error("input register write did not toggle latch");

	AST_IE_OVR: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		ie_ovr_en[2] |-> (o_input_en[2] == ovr_eff[2].input_enable_override_value))
		else $error("pin 2 input enable ignores override");

	AST_FLAG: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(!o_pin_input[6]) ##1 (o_pin_input[6] &&
		i_ext_int_sense[6] == ppm_pkg::SENSE_RISE) |=> o_ext_int_flag[6])
		else $error("rising edge on pin 6 missed its flag");

	AST_SYNC: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(o_input_en[3] && i_pad_in[3])[*3] |-> o_pin_input[3])
		else $error("pin 3 input not through synchroniser in time");

	AST_ROUTE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		o_timer1_count_source == (i_pad_in[4] & o_input_en[4]))
		else $error("pin 4 count source not the gated pad");

	AST_PIN_CHG: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		o_pin_change_source == (i_pad_in & o_input_en))
		else $error("pin change sources not the gated pads");

	AST_PAD_OFF: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(o_pad_out & ~o_pad_oe) == 8'h00)
		else $error("pad value driven while driver disabled");

	AST_USI_PRI: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(o_pad_oe[5] && i_usi_data_out_en) |->
		(o_pad_out[5] == i_usi_data_out))
		else $error("pin 5 not driven by serial data out");

	AST_T1_CMPA: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		(o_pad_oe[6] && i_timer1_compare_a_en) |->
		(o_pad_out[6] == i_timer1_compare_a_out))
		else $error("pin 6 not driven by timer 1 compare A");
endmodule
`default_nettype wire

// ---- testbench/ppm_periph_model.sv ----
// Peripheral model driving pin overrides and alternate outputs
`timescale 1ns/100ps
`default_nettype none
module ppm_periph_model (
	// Clock
	input wire logic i_core_clk,
	// Commands from the bench
	input wire logic i_slow,
	input wire ppm_pkg::ppm_ovr_s i_cmd,
	input wire logic [7:0] i_pins,
	input wire logic [3:0] i_val,
	input wire logic [3:0] i_en,
	// Toward the port
	output var ppm_pkg::ppm_ovr_s [7:0] o_ovr,
	output logic [3:0] o_val,
	output logic [3:0] o_en
);
	ppm_pkg::ppm_ovr_s [7:0] ovr_nxt;
	ppm_pkg::ppm_ovr_s [7:0] ovr_r;
	// -----------------------------------------
	// Override generation, one set per pin
	// -----------------------------------------
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			ovr_nxt[i] = i_pins[i] ? i_cmd : '0;
		end
	end
	// Slow mode answers one cycle later; released values show their inverse
	always_ff @(posedge i_core_clk) begin
		ovr_r <= ovr_nxt;
		o_ovr <= i_slow ? ovr_r : ovr_nxt;
		o_en <= i_en;
		o_val <= ~(i_en ^ i_val);
	end
endmodule
`default_nettype wire

// ---- testbench/port_pin_override_mux_tb.sv ----
// Self-checking bench for the port pin override mux
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module port_pin_override_mux_tb;
	logic clk = 0;
	logic rst = 1;
	logic gpd = 0;
	logic slow = 0;
	logic [2:0] wen = '0;
	logic [7:0] wd = '0, eien = '0, fclr = '0, pad = '0, pins = '0;
	logic [3:0] pval = '0, pen = '0, mval, men;
	ppm_pkg::ppm_sleep_e slp = ppm_pkg::SLP_ACTIVE;
	ppm_pkg::ppm_sense_e [7:0] sense;
	ppm_pkg::ppm_ovr_s cmd = '0;
	ppm_pkg::ppm_ovr_s [7:0] ovr;
	logic [7:0] dir, lat, pin_in, flag, pcs, pout, poe, pu, ien;
	logic clamp, sclk, udi, t0c, t1c, cap;
	int n_errors = 0, check_count = 0, cycles = 0;
	always #5 clk = ~clk;
	ppm_periph_model u_per (.i_core_clk(clk), .i_slow(slow), .i_cmd(cmd), .i_pins(pins),
		.i_val(pval), .i_en(pen), .o_ovr(ovr), .o_val(mval), .o_en(men));
	ppm_port dut (.i_core_clk(clk), .i_sys_rst(rst), .i_direction_wr(wen[0]),
		.i_direction_wdata(wd), .i_latch_wr(wen[1]), .i_latch_wdata(wd), .i_pin_wr(wen[2]),
		.i_pin_wdata(wd), .o_direction(dir), .o_output_latch(lat), .o_pin_input(pin_in),
		.i_global_pullup_disable(gpd), .i_sleep_mode(slp), .o_sleep_clamp(clamp),
		.i_ext_int_en(eien), .i_ext_int_sense(sense), .i_ext_int_flag_clr(fclr),
		.o_ext_int_flag(flag), .i_ovr(ovr), .i_usi_data_out(mval[0]),
		.i_usi_data_out_en(men[0]), .i_timer1_compare_a_out(mval[2]),
		.i_timer1_compare_a_en(men[2]), .i_timer1_compare_b_out(mval[1]),
		.i_timer1_compare_b_en(men[1]), .i_timer0_compare_b_out(mval[3]),
		.i_timer0_compare_b_en(men[3]), .o_pin_change_source(pcs),
		.o_serial_iface_clock_pin(sclk), .o_usi_data_in(udi), .o_timer0_count_source(t0c),
		.o_timer1_count_source(t1c), .o_timer1_capture_in(cap), .i_pad_in(pad),
		.o_pad_out(pout), .o_pad_oe(poe), .o_pullup(pu), .o_input_en(ien));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(logic [2:0] s, logic [7:0] v);
		@(posedge clk);
		wen <= s;
		wd <= v;
		@(posedge clk);
		wen <= '0;
		#1;
	endtask
	task automatic per(ppm_pkg::ppm_ovr_s c, logic [7:0] p);
		@(posedge clk);
		cmd <= c;
		pins <= p;
		tick(slow ? 2 : 1);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		@(posedge clk);
		slp <= ppm_pkg::SLP_POWER_DOWN;
		pad <= 8'hFF;
		tick(3);
		`CHK(clamp, 1'b0)
		`CHK(ien, 8'hFF)
		`CHK(pu, 8'h00)
		@(posedge clk);
		rst <= 0;
		slp <= ppm_pkg::SLP_ACTIVE;
		pad <= 8'h00;
		tick(1);
	endtask
	task automatic t_gpio;
		wr(3'b001, 8'h0F);
		`CHK(dir, 8'h0F)
		`CHK(poe, 8'h0F)
		wr(3'b010, 8'hA5);
		`CHK(pout, 8'h05)
		`CHK(pu, 8'hA0)
		@(posedge clk);
		gpd <= 1;
		tick(0);
		`CHK(pu, 8'h00)
		@(posedge clk);
		gpd <= 0;
		wr(3'b100, 8'h81);
		`CHK(lat, 8'h24)
		`CHK(pout, 8'h04)
		@(posedge clk);
		rst <= 1;
		tick(0);
		`CHK(pu, 8'h00)
		tick(2);
		rst <= 0;
		tick(1);
	endtask
	task automatic t_ovr;
		ppm_pkg::ppm_ovr_s c;
		c = '0;
		c.pullup_override_enable = 1;
		c.direction_override_enable = 1;
		c.direction_override_value = 1;
		c.value_override_enable = 1;
		wr(3'b010, 8'hFF);
		slow <= 1;
		per(c, 8'hF0);
		`CHK(pu, 8'h0F)
		`CHK(poe, 8'hF0)
		`CHK(pout, 8'h00)
		per('0, 8'h00);
		`CHK(pu, 8'hFF)
		slow <= 0;
		c = '0;
		c.toggle_override_enable = 1;
		@(posedge clk);
		cmd <= c;
		pins <= 8'h11;
		@(posedge clk);
		cmd <= '0;
		tick(3);
		`CHK(lat, 8'hEE)
	endtask
	task automatic t_sleep;
		ppm_pkg::ppm_ovr_s c;
		logic [7:0] e;
		@(posedge clk);
		eien <= 8'h21;
		pad <= 8'hFF;
		for (int i = 0; i < 5; i++) begin
			e = (i >= 2) ? 8'h21 : 8'hFF;
			@(posedge clk);
			slp <= ppm_pkg::ppm_sleep_e'(i);
			tick(0);
			`CHK(clamp, i >= 2)
			`CHK(ien, e)
			`CHK(pcs, e)
			tick(2);
			`CHK(pin_in, e)
		end
		c = '0;
		c.input_enable_override_enable = 1;
		c.input_enable_override_value = 1;
		@(posedge clk);
		slp <= ppm_pkg::SLP_POWER_DOWN;
		per(c, 8'h04);
		`CHK(ien, 8'h25)
		@(posedge clk);
		slp <= ppm_pkg::SLP_ACTIVE;
		eien <= 8'h00;
		per('0, 8'h00);
	endtask
	task automatic t_sync;
		@(posedge clk);
		pad <= 8'h00;
		tick(2);
		@(posedge clk);
		pad <= 8'h5A;
		tick(0);
		`CHK(pcs, 8'h5A)
		`CHK(pin_in, 8'h00)
		tick(1);
		`CHK(pin_in, 8'h5A)
	endtask
	task automatic t_wake;
		@(posedge clk);
		fclr <= 8'hFF;
		sense[2] <= ppm_pkg::SENSE_FALL;
		sense[3] <= ppm_pkg::SENSE_ANY;
		sense[6] <= ppm_pkg::SENSE_RISE;
		pad <= 8'h4C;
		tick(3);
		fclr <= 8'h00;
		@(posedge clk);
		slp <= ppm_pkg::SLP_STANDBY;
		tick(3);
		`CHK(flag, 8'h0C)
		@(posedge clk);
		slp <= ppm_pkg::SLP_ACTIVE;
		tick(3);
		`CHK(flag, 8'h4C)
		@(posedge clk);
		fclr <= 8'hFF;
		tick(1);
		`CHK(flag, 8'h00)
		fclr <= 8'h00;
	endtask
	task automatic t_alt;
		wr(3'b001, 8'hE0);
		@(posedge clk);
		pen <= 4'b1110;
		pval <= 4'b1010;
		tick(1);
		`CHK(pout, 8'hA0)
		@(posedge clk);
		pen <= 4'b1111;
		tick(1);
		`CHK(pout, 8'h80)
		@(posedge clk);
		pad <= 8'h58;
		tick(0);
		`CHK({t0c, t1c, sclk, udi, cap}, 5'b11110)
		@(posedge clk);
		pad <= 8'h80;
		tick(0);
		`CHK({t0c, t1c, sclk, udi, cap}, 5'b00001)
	endtask
	// ----------------------------------------
	// Main sequence and timeout
	// ----------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		for (int i = 0; i < 8; i++) begin
			sense[i] = ppm_pkg::SENSE_LOW;
		end
		t_reset();
		t_gpio();
		t_ovr();
		t_sleep();
		t_sync();
		t_wake();
		t_alt();
		end_sim();
	end
endmodule
`default_nettype wire
